// ---- inc/rtd_map.svh ----
`ifndef RTD_MAP_SVH
`define RTD_MAP_SVH
// Summary of operation
// [R1] Mode fields accept only 0 (no input) or 1 (convert to centigrade).
// [R2] Mode 0 hides the channel offset: not readable, not writable, not applied.
// [R3] Offsets are signed counts of 0.01 degree, limited to -30000..30000.
// [R4] The offset is added to the channel's converted temperature.
// [R5] After reset every mode field and every offset holds zero.
// [R6] Each channel drives its own dedicated corrected measure output.
// [R7] Correction updates only in conversion mode; sums saturate instead of wrapping.

// parameter numbers on the register protocol
`define CHAN1_TEMP_OFFSET_ADDR 16'h0399
`define CHAN2_MEASURE_SELECT_ADDR 16'h039A
`define CHAN2_TEMP_OFFSET_ADDR 16'h039B
`define CHAN3_MEASURE_SELECT_ADDR 16'h039C
`define CHAN3_TEMP_OFFSET_ADDR 16'h039D
`define CHAN4_MEASURE_SELECT_ADDR 16'h039E
`define CHAN4_TEMP_OFFSET_ADDR 16'h039F

`define MODE_MAX 16'h0001
`define MODE_RESET 1'h0
`define OFFSET_RESET 16'h0000
// +30000 and -30000 hundredths of a degree
`define OFFSET_MAX 16'sh7530
`define OFFSET_MIN 16'sh8AD0
`define MEAS_RESET 16'h0000
`define MEAS_POS_SAT 16'h7FFF
`define MEAS_NEG_SAT 16'h8000
`define RDATA_IDLE 16'h0000
`endif

// ---- inc/rtd_pkg.sv ----
package rtd_pkg;
  typedef logic signed [15:0] temp_t;
  typedef enum logic [0:0] {
    MODE_NO_INPUT = 1'b0,
    MODE_RTD_CONVERSION = 1'b1
  } rtd_conversion_mode_t;
  typedef struct packed {
    logic sel;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } par_req_t;
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } par_rsp_t;
endpackage : rtd_pkg

// ---- hw/rtd_channel_corrector.sv ----
`timescale 1ns/10ps
`include "rtd_map.svh"
module rtd_channel_corrector (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_enable,
  input rtd_pkg::temp_t i_offset,
  input rtd_pkg::temp_t i_raw,
  input wire logic i_raw_valid,
  output rtd_pkg::temp_t o_measure,
  output logic o_measure_valid
);
  import rtd_pkg::*;

  temp_t meas_reg;
  temp_t meas_next;
  logic valid_reg;
  logic valid_next;
  logic signed [16:0] sum;

  always_comb begin
    sum = {i_raw[15], i_raw} + {i_offset[15], i_offset}; // [R4]
    meas_next = meas_reg;
    valid_next = 1'b0;
    if (!i_enable) begin
      // a disabled channel reports zero rather than a stale reading
      meas_next = `MEAS_RESET; // [R2]
    end else if (i_raw_valid) begin // [R7]
      valid_next = 1'b1;
      if (sum[16] != sum[15]) begin
        meas_next = sum[16] ? `MEAS_NEG_SAT : `MEAS_POS_SAT; // [R7]
      end else begin
        meas_next = sum[15:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meas_reg <= `MEAS_RESET;
      valid_reg <= 1'b0;
    end else begin
      meas_reg <= meas_next;
      valid_reg <= valid_next;
    end
  end

  assign o_measure = meas_reg;
  assign o_measure_valid = valid_reg;
endmodule : rtd_channel_corrector

// ---- hw/rtd_channel_offset_config.sv ----
`timescale 1ns/10ps
`include "rtd_map.svh"
module rtd_channel_offset_config (
  input wire logic i_clk,
  input wire logic i_rstn,
  input rtd_pkg::par_req_t i_par_req,
  output rtd_pkg::par_rsp_t o_par_rsp,
  input wire logic i_chan1_mode,
  input rtd_pkg::temp_t i_chan1_raw_temp,
  input rtd_pkg::temp_t i_chan2_raw_temp,
  input rtd_pkg::temp_t i_chan3_raw_temp,
  input rtd_pkg::temp_t i_chan4_raw_temp,
  input wire logic [3:0] i_raw_valid,
  output rtd_pkg::temp_t o_chan1_temperature_measure,
  output rtd_pkg::temp_t o_chan2_temperature_measure,
  output rtd_pkg::temp_t o_chan3_temperature_measure,
  output rtd_pkg::temp_t o_chan4_temperature_measure,
  output logic [3:0] o_measure_valid,
  output logic [3:0] o_chan_enabled
);
  import rtd_pkg::*;

  // mode of channels 2..4, indexed by channel number less one;
  // channel 1 mode lives outside this block
  rtd_conversion_mode_t mode_reg [1:3];
  rtd_conversion_mode_t mode_next [1:3];
  temp_t offset_reg [4];
  temp_t offset_next [4];
  par_rsp_t rsp_reg;
  par_rsp_t rsp_next;

  logic [3:0] chan_en;
  logic hit;
  logic is_mode;
  logic [1:0] ch;
  temp_t raw [4];
  temp_t meas [4];

  // request classification, shared by the state groups below
  logic req_wr;
  logic req_rd;
  logic mode_in_range;
  logic offset_in_range;
  logic offset_visible;
  logic refuse;
  logic [3:0] mode_we;
  logic [3:0] offset_we;
  logic [15:0] rdata_sel;

  assign chan_en[0] = i_chan1_mode;
  assign chan_en[1] = (mode_reg[1] == MODE_RTD_CONVERSION);
  assign chan_en[2] = (mode_reg[2] == MODE_RTD_CONVERSION);
  assign chan_en[3] = (mode_reg[3] == MODE_RTD_CONVERSION);

  // address decode
  always_comb begin
    hit = 1'b1;
    is_mode = 1'b0;
    ch = 2'd0;
    unique case (i_par_req.addr)
      `CHAN1_TEMP_OFFSET_ADDR: begin
        ch = 2'd0;
      end
      `CHAN2_MEASURE_SELECT_ADDR: begin
        ch = 2'd1;
        is_mode = 1'b1;
      end
      `CHAN2_TEMP_OFFSET_ADDR: begin
        ch = 2'd1;
      end
      `CHAN3_MEASURE_SELECT_ADDR: begin
        ch = 2'd2;
        is_mode = 1'b1;
      end
      `CHAN3_TEMP_OFFSET_ADDR: begin
        ch = 2'd2;
      end
      `CHAN4_MEASURE_SELECT_ADDR: begin
        ch = 2'd3;
        is_mode = 1'b1;
      end
      `CHAN4_TEMP_OFFSET_ADDR: begin
        ch = 2'd3;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // classify the request once; the state groups only look at the strobes
  always_comb begin
    req_wr = i_par_req.sel && i_par_req.wr;
    req_rd = i_par_req.sel && !i_par_req.wr;
    // compared unsigned, so a set bit 0 with upper bits set is still refused
    mode_in_range = (i_par_req.wdata <= `MODE_MAX); // [R1]
    offset_in_range = ($signed(i_par_req.wdata) <= `OFFSET_MAX) &&
                      ($signed(i_par_req.wdata) >= `OFFSET_MIN); // [R3]
    // enable before this request lands; a mode write acts from the next edge
    offset_visible = chan_en[ch]; // [R2]
    refuse = 1'b0;
    mode_we = 4'h0;
    offset_we = 4'h0;
    if (i_par_req.sel) begin
      if (!hit) begin
        refuse = 1'b1;
      end else if (is_mode) begin
        if (req_wr && !mode_in_range) begin
          // out-of-range writes leave the field untouched
          refuse = 1'b1; // [R1]
        end else if (req_wr) begin
          mode_we[ch] = 1'b1;
        end
      end else if (!offset_visible) begin
        // hidden parameter: refused both ways, stored value kept
        refuse = 1'b1; // [R2]
      end else if (req_wr && !offset_in_range) begin
        refuse = 1'b1; // [R3]
      end else if (req_wr) begin
        offset_we[ch] = 1'b1;
      end
    end
  end

  // mode group
  always_comb begin
    mode_next = mode_reg;
    for (int i = 1; i < 4; i++) begin
      if (mode_we[i]) begin
        mode_next[i] = rtd_conversion_mode_t'(i_par_req.wdata[0]); // [R1]
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 1; i < 4; i++) begin
        mode_reg[i] <= MODE_NO_INPUT; // [R5]
      end
    end else begin
      mode_reg <= mode_next;
    end
  end

  // offset group: a hidden offset keeps its value for when the channel returns
  always_comb begin
    offset_next = offset_reg;
    for (int i = 0; i < 4; i++) begin
      if (offset_we[i]) begin
        offset_next[i] = $signed(i_par_req.wdata); // [R3]
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 4; i++) begin
        offset_reg[i] <= `OFFSET_RESET; // [R5]
      end
    end else begin
      offset_reg <= offset_next;
    end
  end

  // read data; writes and refusals answer with the idle pattern
  always_comb begin
    rdata_sel = `RDATA_IDLE;
    if (req_rd && hit && !refuse) begin
      if (is_mode) begin
        unique case (ch)
          2'h1: rdata_sel = {15'h0000, mode_reg[1]};
          2'h2: rdata_sel = {15'h0000, mode_reg[2]};
          2'h3: rdata_sel = {15'h0000, mode_reg[3]};
          default: rdata_sel = `RDATA_IDLE;
        endcase
      end else begin
        rdata_sel = offset_reg[ch];
      end
    end
  end

  // response group: one answer per request, on the following edge
  always_comb begin
    rsp_next.ack = i_par_req.sel;
    rsp_next.err = refuse;
    rsp_next.rdata = rdata_sel;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign o_par_rsp = rsp_reg;
  assign o_chan_enabled = chan_en;

  assign raw[0] = i_chan1_raw_temp;
  assign raw[1] = i_chan2_raw_temp;
  assign raw[2] = i_chan3_raw_temp;
  assign raw[3] = i_chan4_raw_temp;

  // one corrector per channel, each with its own result
  for (genvar g = 0; g < 4; g++) begin : g_chan
    rtd_channel_corrector u_corr (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_enable(chan_en[g]),
      .i_offset(offset_reg[g]),
      .i_raw(raw[g]),
      .i_raw_valid(i_raw_valid[g]),
      .o_measure(meas[g]),
      .o_measure_valid(o_measure_valid[g])
    );
  end

  assign o_chan1_temperature_measure = meas[0];
  assign o_chan2_temperature_measure = meas[1]; // [R6]
  assign o_chan3_temperature_measure = meas[2]; // [R6]
  assign o_chan4_temperature_measure = meas[3]; // [R6]
endmodule : rtd_channel_offset_config

// ---- bench/rtd_channel_offset_config_sva.sv ----
`timescale 1ns/10ps
`include "rtd_map.svh"
module rtd_channel_offset_config_sva (
  input wire logic i_clk,
  input wire logic i_rstn,
  input rtd_pkg::par_req_t i_par_req,
  input rtd_pkg::par_rsp_t o_par_rsp,
  input wire logic i_chan1_mode,
  input wire logic [3:0] i_raw_valid,
  input rtd_pkg::temp_t o_chan1_temperature_measure,
  input wire logic [3:0] o_measure_valid,
  input wire logic [3:0] o_chan_enabled
);
  import rtd_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_ack; i_par_req.sel |=> o_par_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("request without ack");
  property p_idle; !i_par_req.sel |=> !o_par_rsp.ack; endproperty
  a_idle: assert property (p_idle) else $error("ack without request");
  property p_mode;
    i_par_req.sel && i_par_req.wr && i_par_req.addr == `CHAN2_MEASURE_SELECT_ADDR
      && i_par_req.wdata > `MODE_MAX |=> o_par_rsp.err;
  endproperty
  a_mode: assert property (p_mode) else $error("bad mode accepted");
  property p_hide;
    i_par_req.sel && i_par_req.addr == `CHAN1_TEMP_OFFSET_ADDR && !i_chan1_mode
      |=> o_par_rsp.err;
  endproperty
  a_hide: assert property (p_hide) else $error("hidden offset reachable");
  property p_range;
    i_par_req.sel && i_par_req.wr && i_par_req.addr == `CHAN1_TEMP_OFFSET_ADDR
      && $signed(i_par_req.wdata) > `OFFSET_MAX |=> o_par_rsp.err;
  endproperty
  a_range: assert property (p_range) else $error("offset over range accepted");
  property p_err0; o_par_rsp.err |-> o_par_rsp.ack && o_par_rsp.rdata == 16'h0000; endproperty
  a_err0: assert property (p_err0) else $error("refusal carries data");
  property p_rst;
    $rose(i_rstn) |-> o_chan_enabled[3:1] == 3'h0 && o_chan1_temperature_measure == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("state not cleared by reset");
  property p_meas; i_raw_valid[0] && o_chan_enabled[0] |=> o_measure_valid[0]; endproperty
  a_meas: assert property (p_meas) else $error("strobe not corrected");
  property p_off;
    !o_chan_enabled[0] |=> o_chan1_temperature_measure == 16'h0000 && !o_measure_valid[0];
  endproperty
  a_off: assert property (p_off) else $error("disabled channel updates");
endmodule : rtd_channel_offset_config_sva
bind rtd_channel_offset_config rtd_channel_offset_config_sva u_rtd_channel_offset_config_sva (
  .i_clk, .i_rstn, .i_par_req, .o_par_rsp, .i_chan1_mode, .i_raw_valid,
  .o_chan1_temperature_measure, .o_measure_valid, .o_chan_enabled);

// ---- bench/rtd_channel_offset_config_bench.sv ----
`timescale 1ns/10ps
`include "rtd_map.svh"
module rtd_channel_offset_config_bench;
  import rtd_pkg::*;
  logic i_clk = 0, i_rstn = 0, i_chan1_mode = 0;
  logic [3:0] i_raw_valid = 4'h0, o_measure_valid, o_chan_enabled;
  par_req_t i_par_req = '0;
  par_rsp_t o_par_rsp;
  temp_t raw[4] = '{default: 16'h0000};
  temp_t m[4];
  temp_t off[4] = '{default: 16'h0000};
  logic [17:0] rs;
  logic [19:0] rv;
  logic [15:0] oa;
  int fail_count = 0, checks = 0, v;
  bit bad;
  initial forever #50 i_clk = ~i_clk;
  rtd_channel_offset_config u_rtd_channel_offset_config (.i_clk, .i_rstn, .i_par_req,
    .o_par_rsp, .i_chan1_mode, .i_chan1_raw_temp(raw[0]), .i_chan2_raw_temp(raw[1]),
    .i_chan3_raw_temp(raw[2]), .i_chan4_raw_temp(raw[3]), .i_raw_valid,
    .o_chan1_temperature_measure(m[0]), .o_chan2_temperature_measure(m[1]),
    .o_chan3_temperature_measure(m[2]), .o_chan4_temperature_measure(m[3]),
    .o_measure_valid, .o_chan_enabled);
  function automatic temp_t sat(temp_t r, temp_t o);
    int s;
    s = r + o;
    return (s > 32767) ? 16'h7FFF : (s < -32768) ? 16'h8000 : s[15:0];
  endfunction : sat
  task cmp_rsp(input logic [17:0] exp);
    checks++;
    if (rs !== exp) begin
      fail_count++;
      $display("ERROR t=%0t response got %h exp %h", $time, rs, exp);
    end
  endtask : cmp_rsp
  // all four strobes are compared, so a stray update on another channel shows
  task cmp_meas(input logic [19:0] exp);
    checks++;
    if (rv !== exp) begin
      fail_count++;
      $display("ERROR t=%0t measure got %h exp %h", $time, rv, exp);
    end
  endtask : cmp_meas
  task cmp_en(input logic [3:0] exp);
    checks++;
    if (o_chan_enabled !== exp) begin
      fail_count++;
      $display("ERROR t=%0t enables got %h exp %h", $time, o_chan_enabled, exp);
    end
  endtask : cmp_en
  task acc(input logic wr, input logic [15:0] a, d);
    i_par_req = '{1'b1, wr, a, d};
    @(negedge i_clk);
    rs = o_par_rsp;
    i_par_req.sel = 1'b0;
    @(negedge i_clk);
  endtask : acc
  task meas(input int c, input temp_t r);
    raw[c] = r;
    i_raw_valid[c] = 1'b1;
    @(negedge i_clk);
    rv = {o_measure_valid, m[c]};
    i_raw_valid[c] = 1'b0;
    @(negedge i_clk);
  endtask : meas
  task finish_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    fail_count++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h5DC0));
    repeat (5) @(negedge i_clk);
    i_rstn = 1'b1;
    for (int a = 'h398; a <= 'h3A0; a++) begin
      acc(1'b0, 16'(a), 16'h0000);
      cmp_rsp({1'b1, a[0] || a inside {'h398, 'h3A0}, 16'h0000});
    end
    cmp_en(4'h0);
    acc(1'b1, `CHAN2_MEASURE_SELECT_ADDR, 16'h0002);
    cmp_rsp(18'h30000);
    acc(1'b1, `CHAN3_MEASURE_SELECT_ADDR, 16'h8001);
    cmp_rsp(18'h30000);
    for (int c = 1; c < 4; c++) begin
      oa = `CHAN1_TEMP_OFFSET_ADDR + 16'(2 * c - 1);
      acc(1'b1, oa, 16'h0001);
      cmp_rsp(18'h20000);
      acc(1'b0, oa, 16'h0000);
      cmp_rsp(18'h20001);
    end
    i_chan1_mode = 1'b1;
    @(negedge i_clk);
    cmp_en(4'hF);
    $display("test reset_and_mode done");
    // corners first: full offsets against extreme raw values, then one past the limit
    for (int k = 0; k < 40; k++) begin
      oa = `CHAN1_TEMP_OFFSET_ADDR + 16'(2 * (k % 4));
      v = int'($urandom_range(61000)) - 30500;
      if (k < 4) v = k[0] ? 30000 : -30000;
      else if (k < 8) v = k[0] ? -30001 : 30001;
      bad = v > 30000 || v < -30000;
      acc(1'b1, oa, 16'(v));
      cmp_rsp({1'b1, bad, 16'h0000});
      if (!bad) off[k % 4] = 16'(v);
      acc(1'b0, oa, 16'h0000);
      cmp_rsp({2'b10, off[k % 4]});
      meas(k % 4, k < 4 ? (k[0] ? 16'h7FFF : 16'h8000) : 16'($urandom));
      cmp_meas({4'(1 << (k % 4)), sat(raw[k % 4], off[k % 4])});
    end
    $display("test offset_correct done");
    acc(1'b1, `CHAN2_MEASURE_SELECT_ADDR, 16'h0000);
    cmp_en(4'hD);
    acc(1'b0, `CHAN2_TEMP_OFFSET_ADDR, 16'h0000);
    cmp_rsp(18'h30000);
    acc(1'b1, `CHAN2_TEMP_OFFSET_ADDR, 16'h0064);
    cmp_rsp(18'h30000);
    meas(1, 16'h1234);
    cmp_meas(20'h00000);
    // the hidden offset must come back unchanged with the channel
    acc(1'b1, `CHAN2_MEASURE_SELECT_ADDR, 16'h0001);
    acc(1'b0, `CHAN2_TEMP_OFFSET_ADDR, 16'h0000);
    cmp_rsp({2'b10, off[1]});
    $display("test disable done");
    i_rstn = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rstn = 1'b1;
    cmp_en(4'h1);
    for (int c = 0; c < 4; c++) begin
      rv = {o_measure_valid, m[c]};
      cmp_meas(20'h00000);
    end
    acc(1'b0, `CHAN1_TEMP_OFFSET_ADDR, 16'h0000);
    cmp_rsp(18'h20000);
    for (int c = 1; c < 4; c++) begin
      oa = `CHAN1_TEMP_OFFSET_ADDR + 16'(2 * c - 1);
      acc(1'b0, oa, 16'h0000);
      cmp_rsp(18'h20000);
      acc(1'b1, oa, 16'h0001);
      acc(1'b0, oa + 16'h0001, 16'h0000);
      cmp_rsp(18'h20000);
    end
    $display("test reset_again done");
    finish_test;
  end
endmodule : rtd_channel_offset_config_bench
